/* File: src/eei_regs.svh */
// register map, field positions and timing constants of the ethernet error injector
// How it works
// RULE_01 - mode off passes traffic untouched
// RULE_02 - manual request inserts exactly burst count
// RULE_03 - burst inserted once every second
// RULE_04 - burst inserted once every ten seconds
// RULE_05 - rate mode bursts at 1E-2 to 1E-7
// RULE_06 - rate denominator counts transmitted blocks
// RULE_07 - insert request in rate mode only shows status
// RULE_08 - software programs the burst length count
// RULE_09 - alarms apply continuously, not in bursts
// RULE_10 - ifg destination shortens the interframe gap
// RULE_11 - fcs destination sends a bad frame check
// RULE_12 - preamble corrupted only at 10G or below
// RULE_13 - ip destination sends wrong header checksum
// RULE_14 - fragment destination sends fragmented ipv4 data
// RULE_15 - layer4 destination sends wrong tcp/udp checksum
// RULE_16 - pattern destination flips payload test bits
// RULE_17 - sequence destination corrupts test sequence number
// RULE_18 - block destination at 10G sends bad block
// RULE_19 - block destination at 1G raises tx error
// RULE_20 - fec destination, 25G/100G with fec only
// RULE_21 - pause destination sends pause frames per event
`ifndef EEI_REGS_SVH
`define EEI_REGS_SVH

// ----------------------------------------------------------------
// register offsets (word index on the register port)
// ----------------------------------------------------------------
`define EEI_ADDR_W        4
`define EEI_OFF_CTRL      4'h0
`define EEI_OFF_BURST     4'h1
`define EEI_OFF_INSERT    4'h2
`define EEI_OFF_STATUS    4'h3
`define EEI_OFF_COUNT     4'h4

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define EEI_CTRL_MODE     2:0
`define EEI_CTRL_DEST     7:4
`define EEI_CTRL_ALARM    8
`define EEI_CTRL_RATE     14:12
`define EEI_CTRL_SPEED    17:16
`define EEI_CTRL_FEC      20
`define EEI_CTRL_RST      32'h0000_0000
`define EEI_BURST_RST     16'h0001

// ----------------------------------------------------------------
// per-block field markers supplied by the frame generator
// ----------------------------------------------------------------
`define EEI_FLD_W         6
`define EEI_FLD_PRE       0
`define EEI_FLD_FCS       1
`define EEI_FLD_IPCK      2
`define EEI_FLD_L4CK      3
`define EEI_FLD_PAT       4
`define EEI_FLD_SEQ       5

// ----------------------------------------------------------------
// corruption patterns
// ----------------------------------------------------------------
`define EEI_FLIP_MASK     64'h0000_0000_0000_0001
`define EEI_BAD_SYNC      2'h0

// ----------------------------------------------------------------
// timing and rate denominators (in blocks)
// ----------------------------------------------------------------
`define EEI_SEC_NS        1000000000
`define EEI_CLK_NS        4
`define EEI_TEN_SECS      4'h9
`define EEI_RATE_E2       24'h00_0064
`define EEI_RATE_E3       24'h00_03E8
`define EEI_RATE_E4       24'h00_2710
`define EEI_RATE_E5       24'h01_86A0
`define EEI_RATE_E6       24'h0F_4240
`define EEI_RATE_E7       24'h98_9680

`endif

/* File: src/eei_pkg.sv */
// types shared by the ethernet error injector modules
package eei_pkg;

  // insertion mode, gray along off-manual-1s-10s-rate
  typedef enum logic [2:0] {
    EEI_MODE_OFF    = 3'h0,
    EEI_MODE_MANUAL = 3'h1,
    EEI_MODE_SEC    = 3'h3,
    EEI_MODE_SEC10  = 3'h2,
    EEI_MODE_RATE   = 3'h6
  } eei_mode_t;

  // insertion destination
  typedef enum logic [3:0] {
    EEI_DST_IFG   = 4'h0,
    EEI_DST_FCS   = 4'h1,
    EEI_DST_PRE   = 4'h2,
    EEI_DST_PAUSE = 4'h3,
    EEI_DST_IPCK  = 4'h4,
    EEI_DST_FRAG  = 4'h5,
    EEI_DST_L4CK  = 4'h6,
    EEI_DST_PAT   = 4'h7,
    EEI_DST_SEQ   = 4'h8,
    EEI_DST_BLK   = 4'h9,
    EEI_DST_FEC   = 4'hA
  } eei_dest_t;

  // port speed class
  typedef enum logic [1:0] {
    EEI_SPD_1G   = 2'h0,
    EEI_SPD_10G  = 2'h1,
    EEI_SPD_25G  = 2'h2,
    EEI_SPD_100G = 2'h3
  } eei_speed_t;

endpackage

/* File: src/eei_event_gen.sv */
// insertion event generator: one and ten second periods and block-counted rate
`timescale 1ns/100ps
`include "eei_regs.svh"
module eei_event_gen #(
  parameter int unsigned SEC_CYCLES = `EEI_SEC_NS / `EEI_CLK_NS  // cycles in one second
) (
  // clock and reset
  input  wire logic              clk_in,
  input  wire logic              resetn_in,
  // settings
  input  wire eei_pkg::eei_mode_t mode_in,
  input  wire logic [2:0]        rate_exp_in,
  // block strobe from the transmit stream
  input  wire logic              blk_valid_in,
  // one-cycle event pulse
  output logic                   event_out
);
  import eei_pkg::*;

  logic [31:0] sec_cnt_reg;    // cycles within the current second
  logic [3:0]  dec_cnt_reg;    // seconds within the ten second period
  logic [23:0] rate_cnt_reg;   // blocks within the rate period
  logic [23:0] rate_lim;       // blocks per burst for the chosen rate
  logic        sec_tick;       // last cycle of a second
  logic        dec_tick;       // last cycle of a ten second period
  logic        rate_tick;      // last block of a rate period
  eei_mode_t   mode_q_reg;     // mode seen last cycle, restarts counts on change
  logic        mode_chg;

  // ----------------------------------------------------------------
  // rate lookup, 1E-2 .. 1E-7; codes 0 and 1 clamp to 1E-2
  // ----------------------------------------------------------------
  always_comb begin
    unique case (rate_exp_in)
      3'h3:    rate_lim = `EEI_RATE_E3;
      3'h4:    rate_lim = `EEI_RATE_E4;
      3'h5:    rate_lim = `EEI_RATE_E5;
      3'h6:    rate_lim = `EEI_RATE_E6;
      3'h7:    rate_lim = `EEI_RATE_E7;
      default: rate_lim = `EEI_RATE_E2;
    endcase
  end

  assign mode_chg  = (mode_q_reg != mode_in);
  assign sec_tick  = (sec_cnt_reg == SEC_CYCLES - 1);
  assign dec_tick  = sec_tick && (dec_cnt_reg == `EEI_TEN_SECS);
  assign rate_tick = blk_valid_in && (rate_cnt_reg == rate_lim - 24'h00_0001); // RULE_06

  // ----------------------------------------------------------------
  // free counters, restarted whenever software changes the mode
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sec_cnt_reg  <= 32'h0000_0000;
      dec_cnt_reg  <= 4'h0;
      rate_cnt_reg <= 24'h00_0000;
      mode_q_reg   <= EEI_MODE_OFF;
    end else begin
      mode_q_reg <= mode_in;
      if (mode_chg || sec_tick) begin
        sec_cnt_reg <= 32'h0000_0000;
      end else begin
        sec_cnt_reg <= sec_cnt_reg + 32'h0000_0001;
      end
      if (mode_chg || dec_tick) begin
        dec_cnt_reg <= 4'h0;
      end else if (sec_tick) begin
        dec_cnt_reg <= dec_cnt_reg + 4'h1;
      end
      // a shorter rate picked mid-period would overshoot; restart instead
      if (mode_chg || rate_tick || rate_cnt_reg >= rate_lim) begin
        rate_cnt_reg <= 24'h00_0000;
      end else if (blk_valid_in) begin
        rate_cnt_reg <= rate_cnt_reg + 24'h00_0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // event per mode
  // ----------------------------------------------------------------
  always_comb begin
    unique case (mode_in)
      EEI_MODE_SEC:   event_out = sec_tick && !mode_chg;   // RULE_03
      EEI_MODE_SEC10: event_out = dec_tick && !mode_chg;   // RULE_04
      EEI_MODE_RATE:  event_out = rate_tick && !mode_chg;  // RULE_05
      default:        event_out = 1'b0;
    endcase
  end

endmodule

/* File: src/eei_top.sv */
// ethernet transmit error and alarm injector with register port
//
// Decided for this implementation: the address map and the plain strobed port.
`timescale 1ns/100ps
`include "eei_regs.svh"
module eei_top #(
  parameter int unsigned SEC_CYCLES = `EEI_SEC_NS / `EEI_CLK_NS,  // one second in clock cycles
  parameter int unsigned DATA_W     = 64                          // block payload width
) (
  // clock and reset
  input  wire logic                    clk_in,
  input  wire logic                    resetn_in,
  // register port
  input  wire logic [`EEI_ADDR_W-1:0]  reg_addr_in,
  input  wire logic [31:0]             reg_wdata_in,
  input  wire logic                    reg_wr_in,
  input  wire logic                    reg_rd_in,
  output logic [31:0]                  reg_rdata_out,
  // transmit stream from the generator
  input  wire logic                    blk_valid_in,
  input  wire logic [DATA_W-1:0]       blk_data_in,
  input  wire logic [1:0]              blk_sync_in,
  input  wire logic                    blk_sof_in,
  input  wire logic                    blk_eof_in,
  input  wire logic [`EEI_FLD_W-1:0]   blk_field_in,
  // transmit stream toward the link
  output logic                         tx_valid_out,
  output logic [DATA_W-1:0]            tx_data_out,
  output logic [1:0]                   tx_sync_out,
  output logic                         tx_sof_out,
  output logic                         tx_eof_out,
  output logic                         tx_er_out,
  // requests to the frame generator and fec encoder
  output logic                         ifg_short_out,
  output logic                         pause_req_out,
  output logic                         frag_req_out,
  output logic                         fec_sym_err_out,
  // status
  output logic                         insert_active_out
);
  import eei_pkg::*;

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [31:0] ctrl_reg;        // mode, destination, alarm, rate, speed, fec
  logic [15:0] burst_reg;       // errors per insertion event
  logic [15:0] pend_reg;        // errors still owed to the stream
  logic [15:0] pend_next;
  logic [31:0] count_reg;       // errors inserted since reset, wraps
  logic [31:0] rdata_reg;       // read answer, one cycle after the strobe

  // ----------------------------------------------------------------
  // decoded settings
  // ----------------------------------------------------------------
  eei_mode_t   mode;
  eei_dest_t   dest;
  eei_speed_t  speed;
  logic [2:0]  rate_exp;
  logic        alarm_sel;       // alarm rather than counted errors
  logic        fec_en;          // fec enabled on the port

  assign mode      = eei_mode_t'(ctrl_reg[`EEI_CTRL_MODE]);
  assign dest      = eei_dest_t'(ctrl_reg[`EEI_CTRL_DEST]);
  assign speed     = eei_speed_t'(ctrl_reg[`EEI_CTRL_SPEED]);
  assign rate_exp  = ctrl_reg[`EEI_CTRL_RATE];
  assign alarm_sel = ctrl_reg[`EEI_CTRL_ALARM];
  assign fec_en    = ctrl_reg[`EEI_CTRL_FEC];

  // ----------------------------------------------------------------
  // register port decode
  // ----------------------------------------------------------------
  logic wr_ctrl;
  logic wr_burst;
  logic wr_insert;
  logic manual_evt;             // software insert request that counts
  logic timed_evt;              // periodic or rate event
  logic evt;                    // any event that owes a burst

  assign wr_ctrl    = reg_wr_in && (reg_addr_in == `EEI_OFF_CTRL);
  assign wr_burst   = reg_wr_in && (reg_addr_in == `EEI_OFF_BURST);
  assign wr_insert  = reg_wr_in && (reg_addr_in == `EEI_OFF_INSERT);
  // insert writes only count in manual mode; in rate mode they do nothing
  assign manual_evt = wr_insert && (mode == EEI_MODE_MANUAL);  // RULE_02 RULE_07
  // alarms do not take bursts, so no event is owed while one is selected
  assign evt        = (manual_evt || timed_evt) && !alarm_sel; // RULE_09

  // ----------------------------------------------------------------
  // periodic and rate event source
  // ----------------------------------------------------------------
  eei_event_gen #(
    .SEC_CYCLES (SEC_CYCLES)
  ) u_event_gen (
    .clk_in       (clk_in),
    .resetn_in    (resetn_in),
    .mode_in      (mode),
    .rate_exp_in  (rate_exp),
    .blk_valid_in (blk_valid_in),
    .event_out    (timed_evt)
  );

  // ----------------------------------------------------------------
  // destination availability per port setup
  // ----------------------------------------------------------------
  logic dest_ok;                // destination usable at this speed
  logic pre_ok;
  logic fec_ok;

  assign pre_ok  = (speed == EEI_SPD_1G) || (speed == EEI_SPD_10G);   // RULE_12
  assign fec_ok  = fec_en && ((speed == EEI_SPD_25G) || (speed == EEI_SPD_100G)); // RULE_20

  always_comb begin
    unique case (dest)
      EEI_DST_PRE: dest_ok = pre_ok;
      EEI_DST_FEC: dest_ok = fec_ok;
      EEI_DST_BLK: dest_ok = (speed == EEI_SPD_1G) || (speed == EEI_SPD_10G);
      default:     dest_ok = (dest <= EEI_DST_FEC);
    endcase
  end

  // ----------------------------------------------------------------
  // which block can carry the selected error
  // ----------------------------------------------------------------
  logic target;                 // this block holds the target field or slot

  always_comb begin
    unique case (dest)
      EEI_DST_FCS:   target = blk_field_in[`EEI_FLD_FCS];
      EEI_DST_PRE:   target = blk_field_in[`EEI_FLD_PRE];
      EEI_DST_IPCK:  target = blk_field_in[`EEI_FLD_IPCK];
      EEI_DST_L4CK:  target = blk_field_in[`EEI_FLD_L4CK];
      EEI_DST_PAT:   target = blk_field_in[`EEI_FLD_PAT];
      EEI_DST_SEQ:   target = blk_field_in[`EEI_FLD_SEQ];
      // frame-level requests are tied to a frame start
      EEI_DST_IFG,
      EEI_DST_PAUSE,
      EEI_DST_FRAG:  target = blk_sof_in;
      default:       target = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------
  // hit: corrupt this block
  // ----------------------------------------------------------------
  logic armed;                  // mode on and destination usable
  logic err_hit;                // one counted error spent on this block
  logic alm_hit;                // alarm applied on this block
  logic hit;

  assign armed   = (mode != EEI_MODE_OFF) && dest_ok;        // RULE_01
  assign err_hit = armed && !alarm_sel && (pend_reg != 16'h0000) && blk_valid_in && target;
  assign alm_hit = armed && alarm_sel && blk_valid_in && target; // RULE_09
  assign hit     = err_hit || alm_hit;

  // ----------------------------------------------------------------
  // owed error count: a new burst is added even on a spending cycle
  // ----------------------------------------------------------------
  always_comb begin
    pend_next = pend_reg;
    if (!armed || alarm_sel) begin
      pend_next = 16'h0000;
    end else begin
      if (err_hit) begin
        pend_next = pend_next - 16'h0001;
      end
      if (evt) begin
        pend_next = pend_next + burst_reg;                   // RULE_08
      end
    end
  end

  // ----------------------------------------------------------------
  // data corruption per destination
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] flip_mask;
  logic              flip_data;
  logic              bad_block;
  logic              set_tx_er;

  assign flip_mask = DATA_W'(`EEI_FLIP_MASK);
  assign flip_data = hit && ((dest == EEI_DST_FCS)  ||       // RULE_11
                             (dest == EEI_DST_PRE)  ||       // RULE_12
                             (dest == EEI_DST_IPCK) ||       // RULE_13
                             (dest == EEI_DST_L4CK) ||       // RULE_15
                             (dest == EEI_DST_PAT)  ||       // RULE_16
                             (dest == EEI_DST_SEQ));         // RULE_17
  assign bad_block = hit && (dest == EEI_DST_BLK) && (speed == EEI_SPD_10G); // RULE_18
  assign set_tx_er = hit && (dest == EEI_DST_BLK) && (speed == EEI_SPD_1G);  // RULE_19

  // ----------------------------------------------------------------
  // output stream, one register stage
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tx_valid_out <= 1'b0;
      tx_data_out  <= '0;
      tx_sync_out  <= 2'h0;
      tx_sof_out   <= 1'b0;
      tx_eof_out   <= 1'b0;
      tx_er_out    <= 1'b0;
    end else begin
      tx_valid_out <= blk_valid_in;
      tx_data_out  <= flip_data ? (blk_data_in ^ flip_mask) : blk_data_in;
      tx_sync_out  <= bad_block ? `EEI_BAD_SYNC : blk_sync_in;
      tx_sof_out   <= blk_sof_in;
      tx_eof_out   <= blk_eof_in;
      tx_er_out    <= set_tx_er;
    end
  end

  // ----------------------------------------------------------------
  // side requests, aligned with the block they belong to
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ifg_short_out   <= 1'b0;
      pause_req_out   <= 1'b0;
      frag_req_out    <= 1'b0;
      fec_sym_err_out <= 1'b0;
    end else begin
      ifg_short_out   <= hit && (dest == EEI_DST_IFG);       // RULE_10
      pause_req_out   <= hit && (dest == EEI_DST_PAUSE);     // RULE_21
      frag_req_out    <= hit && (dest == EEI_DST_FRAG);      // RULE_14
      fec_sym_err_out <= hit && (dest == EEI_DST_FEC);       // RULE_20
    end
  end

  // ----------------------------------------------------------------
  // register writes and counters
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl_reg  <= `EEI_CTRL_RST;
      burst_reg <= `EEI_BURST_RST;
      pend_reg  <= 16'h0000;
      count_reg <= 32'h0000_0000;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= reg_wdata_in;
      end
      if (wr_burst) begin
        burst_reg <= reg_wdata_in[15:0];
      end
      pend_reg <= pend_next;
      if (hit) begin
        count_reg <= count_reg + 32'h0000_0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // status and read path
  // ----------------------------------------------------------------
  logic        active;          // something is being inserted now, or rate mode is armed
  logic [31:0] status_word;
  logic [31:0] rd_mux;

  // in rate mode the insert indicator just shows the injector is armed
  assign active      = armed && (alarm_sel || (mode == EEI_MODE_RATE) || (pend_reg != 16'h0000)); // RULE_07
  assign status_word = {15'h0000, dest_ok, pend_reg[14:0], active};

  always_comb begin
    unique case (reg_addr_in)
      `EEI_OFF_CTRL:   rd_mux = ctrl_reg;
      `EEI_OFF_BURST:  rd_mux = {16'h0000, burst_reg};
      `EEI_OFF_STATUS: rd_mux = status_word;
      `EEI_OFF_COUNT:  rd_mux = count_reg;
      default:         rd_mux = 32'h0000_0000;
    endcase
  end

  // read data stand for the one cycle after the strobe only
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= reg_rd_in ? rd_mux : 32'h0000_0000;
    end
  end

  assign reg_rdata_out     = rdata_reg;
  assign insert_active_out = active;

endmodule

/* File: verif/eei_chk.sv */
// port checker for the error injector
`timescale 1ns/100ps
`include "eei_regs.svh"
module eei_chk #(
  parameter int unsigned SEC_CYCLES = 40,  // one second in cycles
  parameter int unsigned DATA_W     = 64   // block width
) (
  // clock, reset and register port
  input wire logic              clk_in,
  input wire logic              resetn_in,
  input wire logic [3:0]        reg_addr_in,
  input wire logic [31:0]       reg_wdata_in,
  input wire logic              reg_wr_in,
  input wire logic              reg_rd_in,
  input wire logic [31:0]       reg_rdata_out,
  // stream in and out
  input wire logic              blk_valid_in,
  input wire logic [DATA_W-1:0] blk_data_in,
  input wire logic [1:0]        blk_sync_in,
  input wire logic              blk_sof_in,
  input wire logic              tx_valid_out,
  input wire logic [DATA_W-1:0] tx_data_out,
  input wire logic [1:0]        tx_sync_out,
  input wire logic              tx_sof_out,
  input wire logic              tx_er_out,
  input wire logic              ifg_short_out,
  input wire logic              pause_req_out,
  input wire logic              fec_sym_err_out
);
  import eei_pkg::*;
  // ----------------
  // settings shadow
  // ----------------
  logic [31:0] ctrl_reg;                   // last control word
  logic [15:0] burst_reg;                  // last burst length
  wire  [3:0]  dest_w  = ctrl_reg[7:4];    // destination
  wire  [1:0]  speed_w = ctrl_reg[17:16];  // speed class
  // writes land one cycle on
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl_reg  <= `EEI_CTRL_RST;
      burst_reg <= `EEI_BURST_RST;
    end else if (reg_wr_in) begin
      if (reg_addr_in == `EEI_OFF_CTRL) ctrl_reg <= reg_wdata_in;
      if (reg_addr_in == `EEI_OFF_BURST) burst_reg <= reg_wdata_in[15:0];
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // a block taken while insertion is off
  sequence s_off_blk;
    blk_valid_in && ctrl_reg[2:0] == EEI_MODE_OFF;
  endsequence
  // a read strobe aimed at the burst length
  sequence s_burst_rd;
    reg_rd_in && reg_addr_in == `EEI_OFF_BURST;
  endsequence
  a_stream_copy: assert property (blk_valid_in |=> tx_valid_out && tx_sof_out == $past(blk_sof_in))
    else $error("stream copy late");
  a_off_clean: assert property (s_off_blk |=> tx_data_out == $past(blk_data_in) && !tx_er_out
    && tx_sync_out == $past(blk_sync_in) && !ifg_short_out && !pause_req_out && !fec_sym_err_out)
    else $error("altered while off");
  a_rdata_idle: assert property (!reg_rd_in |=> reg_rdata_out == 32'h0)
    else $error("stray read data");
  a_burst_back: assert property (s_burst_rd |=> reg_rdata_out[15:0] == $past(burst_reg))
    else $error("burst readback");
  a_er_cause: assert property (tx_er_out |-> $past(dest_w) == EEI_DST_BLK && $past(speed_w) == EEI_SPD_1G)
    else $error("stray tx error");
  a_sync_cause: assert property (tx_valid_out && tx_sync_out != $past(blk_sync_in)
    |-> $past(dest_w) == EEI_DST_BLK && $past(speed_w) == EEI_SPD_10G)
    else $error("stray sync change");
  a_fec_cause: assert property (fec_sym_err_out
    |-> $past(dest_w) == EEI_DST_FEC && $past(ctrl_reg[20]) && $past(speed_w[1]))
    else $error("stray fec error");
  a_pause_sof: assert property (pause_req_out |-> tx_sof_out && $past(dest_w) == EEI_DST_PAUSE)
    else $error("stray pause request");
  a_ifg_sof: assert property (ifg_short_out |-> tx_sof_out && $past(dest_w) == EEI_DST_IFG)
    else $error("stray short gap");
endmodule
bind eei_top eei_chk #(.SEC_CYCLES(SEC_CYCLES), .DATA_W(DATA_W)) u_chk (.*);

/* File: verif/eei_sink.sv */
// receiving port model: tallies blocks and errored blocks off the link
`timescale 1ns/100ps
module eei_sink (
  // link side
  input  wire logic clk_in,
  input  wire logic resetn_in,
  input  wire logic tx_valid_in,
  input  wire logic tx_er_in,
  // tallies
  output int        blk_cnt_out,
  output int        er_cnt_out
);
  // no back-pressure: the model only listens
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      blk_cnt_out <= 0;
      er_cnt_out  <= 0;
    end else begin
      blk_cnt_out <= blk_cnt_out + int'(tx_valid_in);
      er_cnt_out  <= er_cnt_out + int'(tx_er_in);
    end
  end
endmodule

/* File: verif/eei_tb.sv */
// self-checking bench for the error injector
`timescale 1ns/100ps
`include "eei_regs.svh"
module tb;
  import eei_pkg::*;
  // ----------------
  // signals and model state
  // ----------------
  logic        clk_in = 0, resetn_in = 0, reg_wr_in = 0, reg_rd_in = 0;
  logic [3:0]  reg_addr_in = '0;
  logic [31:0] reg_wdata_in = '0, reg_rdata_out;
  logic        blk_valid_in = 0, blk_sof_in = 0, blk_eof_in = 0;
  logic [63:0] blk_data_in = '0, tx_data_out;
  logic [1:0]  blk_sync_in = 2'h1, tx_sync_out;
  logic [5:0]  blk_field_in = '0;
  logic        tx_valid_out, tx_sof_out, tx_eof_out, tx_er_out, insert_active_out;
  logic        ifg_short_out, pause_req_out, frag_req_out, fec_sym_err_out;
  int          err_total = 0, total_checks = 0, owed = 0, cnt_exp = 0, er_exp = 0;
  int          blk_cnt, er_cnt;
  int          seed = 32'h94B69F69;
  // rows: effect[22:16] field[15:12] kind[11:8] fec,speed[7:4] dest[3:0]
  int rows [14] = '{24'h080100, 24'h011001, 24'h010012, 24'h100103,
                    24'h012004, 24'h200105, 24'h013006, 24'h014007,
                    24'h015008, 24'h040209, 24'h020219, 24'h40026A,
                    24'h000022, 24'h00025A};
  // timed modes: 1 s, 10 s, 1E-2, 1E-3, alarm
  int mc [5] = '{32'h13, 32'h12, 32'h2016, 32'h3016, 32'h111};
  int mn [5] = '{400, 4000, 1000, 10000, 100};
  eei_top #(.SEC_CYCLES(40), .DATA_W(64)) uut (.*);
  eei_sink u_sink (.clk_in(clk_in), .resetn_in(resetn_in), .tx_valid_in(tx_valid_out),
                   .tx_er_in(tx_er_out), .blk_cnt_out(blk_cnt), .er_cnt_out(er_cnt));
  always #2 clk_in = ~clk_in;
  // ----------------
  // tasks
  // ----------------
  task automatic chk(input string n, input logic [63:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic end_of_test;
    if (err_total == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_wr_in    <= 1;
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    @(posedge clk_in);
    reg_wr_in <= 0;
  endtask
  // data stand one cycle
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_in);
    reg_rd_in   <= 1;
    reg_addr_in <= a;
    @(posedge clk_in);
    reg_rd_in <= 0;
    #1 d = reg_rdata_out;
  endtask
  // one block, judged a cycle later
  task automatic send(input int e, k, fb);
    logic [63:0] d;
    logic [5:0]  f;
    logic        s, hit;
    d = {$random(seed), $random(seed)};
    f = 6'($random(seed));
    s = 1'($random(seed));
    hit = owed > 0 && (k == 2 || (k == 1 ? s : f[fb]));
    @(posedge clk_in);
    blk_valid_in <= 1;
    blk_data_in  <= d;
    blk_field_in <= f;
    blk_sof_in   <= s;
    @(posedge clk_in);
    blk_valid_in <= 0;
    #1;
    owed    -= int'(hit);
    cnt_exp += int'(hit);
    er_exp  += int'(hit && e[2]);
    chk("tx_data", tx_data_out, d ^ {63'h0, hit & e[0]});
    chk("effects", {fec_sym_err_out, frag_req_out, pause_req_out, ifg_short_out, tx_er_out,
        tx_sync_out == 2'h0}, 6'(hit ? e[6:1] : 0));
  endtask
  // ----------------
  // main sequence
  // ----------------
  initial begin
    logic [31:0] v;
    int          r, b, c0;
    repeat (4) @(posedge clk_in);
    resetn_in <= 1;
    rd(`EEI_OFF_CTRL, v);
    chk("ctrl", v, `EEI_CTRL_RST);
    rd(`EEI_OFF_BURST, v);
    chk("burst", v[15:0], `EEI_BURST_RST);
    r = {$random(seed)} % 11;
    rd(4'(5 + r), v);
    chk("unmapped", v, 0);
    foreach (rows[i]) begin
      r = rows[i];
      b = 1 + {$random(seed)} % 3;
      wr(`EEI_OFF_CTRL, 32'h0);
      owed = 0;
      send(r[22:16], r[11:8], r[15:12]);
      wr(`EEI_OFF_BURST, b);
      wr(`EEI_OFF_CTRL, {11'h0, r[6], 2'h0, r[5:4], 8'h0, r[3:0], 4'h1});
      wr(`EEI_OFF_INSERT, 32'h0);
      // unusable pairings owe nothing
      owed = r[22:16] != 0 ? b : 0;
      repeat (12) send(r[22:16], r[11:8], r[15:12]);
      rd(`EEI_OFF_COUNT, v);
      chk("count", v, cnt_exp);
      rd(`EEI_OFF_STATUS, v);
      chk("pending", v[15:1], owed);
    end
    chk("er_seen", er_cnt, er_exp);
    // every block a target; window covers the last burst's spends
    @(posedge clk_in);
    blk_field_in <= 6'h3F;
    blk_valid_in <= 1;
    foreach (mc[i]) begin
      b = 1 + {$random(seed)} % 3;
      wr(`EEI_OFF_CTRL, 32'h0);
      wr(`EEI_OFF_BURST, b);
      wr(`EEI_OFF_CTRL, mc[i]);
      rd(`EEI_OFF_STATUS, v);
      if (i > 1) chk("active", {v[0], insert_active_out}, 2'h3);
      rd(`EEI_OFF_COUNT, v);
      c0 = v;
      wr(`EEI_OFF_INSERT, 32'h0);
      repeat (mn[i] - 3) @(posedge clk_in);
      rd(`EEI_OFF_COUNT, v);
      chk("window", v - c0, i == 4 ? mn[i] + 1 : 10 * b);
    end
    blk_valid_in <= 0;
    end_of_test();
  end
  // hang guard
  initial begin
    repeat (100000) @(posedge clk_in);
    err_total++;
    end_of_test();
  end
endmodule
